/* File: ucs_pkg.sv */
package ucs_pkg;

    localparam logic [15:0] CTRL_ADDR      = 16'h1f00;
    localparam logic [15:0] CTRL_RESET     = 16'h0000;
    localparam int          SCALE_MSB      = 15;
    localparam int          SCALE_LSB      = 12;
    localparam int          HALVE_BIT      = 11;
    localparam int          COUNT_MSB      = 10;
    localparam int          COUNT_LSB      = 3;
    localparam int          FORCE_ON_BIT   = 2;
    localparam int          MODE_BIT       = 1;
    localparam int          ELAPSED_BIT    = 0;
    localparam logic [3:0]  TICK_DIVIDE    = 4'hf;
    localparam logic [3:0]  SCALE_MAX_CODE = 4'hf;

    typedef enum logic [2:0] {
        UCS_MUL_1      = 3'h0,
        UCS_MUL_K      = 3'h1,
        UCS_MUL_K_HALF = 3'h2,
        UCS_MUL_KM1_Q  = 3'h3,
        UCS_DIV_2      = 3'h4,
        UCS_DIV_4      = 3'h5
    } ucs_ratio_type;

endpackage : ucs_pkg

/* File: ucs_tick_if.sv */
`timescale 1ns/1ps
interface ucs_tick_if;
    logic run;
    logic tick;
    modport ctrl (output run, input tick);
    modport div  (input run, output tick);
endinterface : ucs_tick_if

/* File: ucs_tick_div.sv */
`timescale 1ns/1ps
module ucs_tick_div (
    // Clock and reset
    input  wire logic  clk_i,
    input  wire logic  resetn_i,
    input  wire logic  ref_en_i,
    // Control side
    ucs_tick_if.div    tif
);
    logic [3:0] cnt_reg;

    // One tick per sixteen reference clock cycles while running.
    always_ff @(posedge clk_i) begin
        if (!resetn_i || !tif.run) begin
            cnt_reg <= 4'h0;
        end else if (ref_en_i) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end

    assign tif.tick = tif.run && ref_en_i && (cnt_reg == ucs_pkg::TICK_DIVIDE);
endmodule : ucs_tick_div

/* File: ucs_synth_ctrl.sv */
`timescale 1ns/1ps
// How it works
// - Synthesizer output feeds the USB clock only when source select is 1.
// - After reset mode is bypass, input divided only.
// - Control register answers at I/O address 1f00.
// - Oscillator enable is mode bit OR force-on bit.
// - Scale factor K equals the 4-bit code plus one.
// - Halving bit matters only in lock mode.
// - Countdown field is bits 10 to 3, read/write, 0 to 255.
// - After mode rises, countdown drops once every 16 reference cycles.
// - Elapsed flag at bit 0 sets when countdown reaches zero.
// - Mode 0 selects bypass; mode 1 selects lock and starts oscillator.
// - Force-on 1 starts oscillator; 0 stops it only if mode is 0.
// - Bypass divides by two for K 1-15, by four for K 16.
// - Lock, halving 0: times K for K 1-15, times one for 16.
// - Lock, halving 1: K/2 for odd K, (K-1)/4 for even K.
module ucs_synth_ctrl (
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RESETN_I,
    // Reference input clock, raw from its pin
    input  wire logic        REF_CLK_I,
    // I/O space access
    input  wire logic [15:0] IO_ADDR_I,
    input  wire logic        IO_WR_I,
    input  wire logic        IO_RD_I,
    input  wire logic [15:0] IO_WDATA_I,
    output logic      [15:0] IO_RDATA_O,
    output logic             IO_SEL_O,
    // Clock source selection
    input  wire logic        SYNTH_SOURCE_SELECT_I,
    output logic             SYNTH_USED_O,
    // Analog synthesizer controls
    output logic             OSC_ENABLE_O,
    output logic             LOCK_MODE_O,
    output logic      [3:0]  SCALE_FACTOR_CODE_O,
    output logic      [4:0]  SCALE_K_O,
    output logic      [2:0]  RATIO_O,
    output logic             LOCK_ELAPSED_O
);
    logic [2:0]  ref_sync_reg;
    logic        ref_en;
    logic [3:0]  scale_reg;
    logic        halve_reg;
    logic [7:0]  count_reg;
    logic        force_on_reg;
    logic        mode_reg;
    logic        elapsed_reg;
    logic        counting_reg;
    logic        hit;
    logic        wr;
    logic        mode_next;
    ucs_pkg::ucs_ratio_type ratio_next;

    ucs_tick_if tif ();

    // Reference clock is sampled twice before any logic looks at it.
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            ref_sync_reg <= 3'h0;
        end else begin
            ref_sync_reg <= {ref_sync_reg[1:0], REF_CLK_I};
        end
    end

    assign ref_en = ref_sync_reg[1] && !ref_sync_reg[2];

    assign hit       = (IO_ADDR_I == ucs_pkg::CTRL_ADDR);
    assign wr        = hit && IO_WR_I;
    assign mode_next = wr ? IO_WDATA_I[ucs_pkg::MODE_BIT] : mode_reg;
    assign IO_SEL_O  = hit && (IO_WR_I || IO_RD_I);

    // Configuration fields.
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            scale_reg    <= ucs_pkg::CTRL_RESET[ucs_pkg::SCALE_MSB:ucs_pkg::SCALE_LSB];
            halve_reg    <= ucs_pkg::CTRL_RESET[ucs_pkg::HALVE_BIT];
            force_on_reg <= ucs_pkg::CTRL_RESET[ucs_pkg::FORCE_ON_BIT];
            mode_reg     <= ucs_pkg::CTRL_RESET[ucs_pkg::MODE_BIT];
        end else if (wr) begin
            scale_reg    <= IO_WDATA_I[ucs_pkg::SCALE_MSB:ucs_pkg::SCALE_LSB];
            halve_reg    <= IO_WDATA_I[ucs_pkg::HALVE_BIT];
            force_on_reg <= IO_WDATA_I[ucs_pkg::FORCE_ON_BIT];
            mode_reg     <= IO_WDATA_I[ucs_pkg::MODE_BIT];
        end
    end

    // Countdown runs from the rising edge of mode until a tick finds the count already at zero.
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            counting_reg <= 1'b0;
        end else if (!mode_next) begin
            counting_reg <= 1'b0;
        end else if (!mode_reg) begin
            counting_reg <= 1'b1;
        end else if (tif.tick && count_reg == 8'h00) begin
            counting_reg <= 1'b0;
        end
    end

    assign tif.run = counting_reg;

    // A tick at a nonzero count wins over a software write to the count in the same cycle.
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            count_reg <= ucs_pkg::CTRL_RESET[ucs_pkg::COUNT_MSB:ucs_pkg::COUNT_LSB];
        end else if (tif.tick && count_reg != 8'h00) begin
            count_reg <= count_reg - 8'h01;
        end else if (wr) begin
            count_reg <= IO_WDATA_I[ucs_pkg::COUNT_MSB:ucs_pkg::COUNT_LSB];
        end
    end

    // Elapsed flag: set wins over the clear from a mode drop.
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            elapsed_reg <= 1'b0;
        end else if (counting_reg && mode_reg && count_reg == 8'h00
                     && (tif.tick || !counting_reg)) begin
            elapsed_reg <= 1'b1;
        end else if (counting_reg && tif.tick && count_reg == 8'h01) begin
            elapsed_reg <= 1'b1;
        end else if (!mode_next) begin
            elapsed_reg <= 1'b0;
        end
    end

    ucs_tick_div u_tick (
        .clk_i    (CLK_I),
        .resetn_i (RESETN_I),
        .ref_en_i (ref_en),
        .tif      (tif)
    );

    // Output ratio selection.
    always_comb begin
        ratio_next = ucs_pkg::UCS_DIV_2;
        if (!mode_reg) begin
            ratio_next = (scale_reg == ucs_pkg::SCALE_MAX_CODE) ? ucs_pkg::UCS_DIV_4
                                                                : ucs_pkg::UCS_DIV_2;
        end else if (!halve_reg) begin
            ratio_next = (scale_reg == ucs_pkg::SCALE_MAX_CODE) ? ucs_pkg::UCS_MUL_1
                                                                : ucs_pkg::UCS_MUL_K;
        end else begin
            ratio_next = scale_reg[0] ? ucs_pkg::UCS_MUL_KM1_Q
                                      : ucs_pkg::UCS_MUL_K_HALF;
        end
    end

    // Read data and control outputs come from flip-flops.
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            IO_RDATA_O          <= 16'h0000;
            SYNTH_USED_O        <= 1'b0;
            OSC_ENABLE_O        <= 1'b0;
            LOCK_MODE_O         <= 1'b0;
            SCALE_FACTOR_CODE_O <= 4'h0;
            SCALE_K_O           <= 5'h01;
            RATIO_O             <= 3'h4;
            LOCK_ELAPSED_O      <= 1'b0;
        end else begin
            IO_RDATA_O          <= (hit && IO_RD_I)
                                   ? {scale_reg, halve_reg, count_reg, force_on_reg,
                                      mode_reg, elapsed_reg}
                                   : 16'h0000;
            SYNTH_USED_O        <= SYNTH_SOURCE_SELECT_I;
            OSC_ENABLE_O        <= mode_reg || force_on_reg;
            LOCK_MODE_O         <= mode_reg;
            SCALE_FACTOR_CODE_O <= scale_reg;
            SCALE_K_O           <= {1'b0, scale_reg} + 5'h01;
            RATIO_O             <= ratio_next;
            LOCK_ELAPSED_O      <= elapsed_reg;
        end
    end

endmodule : ucs_synth_ctrl

/* File: ucs_synth_ctrl_checker.sv */
`timescale 1ns/1ps
module ucs_synth_ctrl_checker (
    input wire logic        CLK_I, RESETN_I, IO_WR_I, IO_RD_I, IO_SEL_O,
    input wire logic [15:0] IO_ADDR_I, IO_WDATA_I, IO_RDATA_O,
    input wire logic        SYNTH_SOURCE_SELECT_I, SYNTH_USED_O, OSC_ENABLE_O,
    input wire logic        LOCK_MODE_O, LOCK_ELAPSED_O,
    input wire logic [3:0]  SCALE_FACTOR_CODE_O,
    input wire logic [4:0]  SCALE_K_O,
    input wire logic [2:0]  RATIO_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    wire hit = IO_ADDR_I == ucs_pkg::CTRL_ADDR;
    property p_sel; IO_SEL_O == (hit && (IO_WR_I || IO_RD_I)); endproperty
    a_sel: assert property (p_sel) else $error("bad select");
    property p_miss; IO_RD_I && !hit |=> IO_RDATA_O == 16'h0000; endproperty
    a_miss: assert property (p_miss) else $error("bad miss read");
    // The field is stored at the write edge and reaches the output pins one edge later.
    property p_mode;
        IO_WR_I && hit |-> ##2 LOCK_MODE_O == $past(IO_WDATA_I[ucs_pkg::MODE_BIT], 2);
    endproperty
    a_mode: assert property (p_mode) else $error("bad mode");
    property p_osc;
        IO_WR_I && hit |-> ##2 OSC_ENABLE_O == ($past(IO_WDATA_I[ucs_pkg::MODE_BIT], 2)
                                               | $past(IO_WDATA_I[ucs_pkg::FORCE_ON_BIT], 2));
    endproperty
    a_osc: assert property (p_osc) else $error("bad osc");
    property p_k; SCALE_K_O == {1'b0, SCALE_FACTOR_CODE_O} + 5'h01; endproperty
    a_k: assert property (p_k) else $error("bad k");
    property p_byp;
        !LOCK_MODE_O |-> RATIO_O == ((SCALE_FACTOR_CODE_O == 4'hf) ? 3'h5 : 3'h4);
    endproperty
    a_byp: assert property (p_byp) else $error("bad bypass ratio");
    // A final tick in the cycle of a mode drop may show the flag for one cycle.
    property p_clr; !LOCK_MODE_O && !$fell(LOCK_MODE_O) |-> !LOCK_ELAPSED_O; endproperty
    a_clr: assert property (p_clr) else $error("flag in bypass");
    property p_used; $past(RESETN_I) |-> SYNTH_USED_O == $past(SYNTH_SOURCE_SELECT_I); endproperty
    a_used: assert property (p_used) else $error("bad source use");
    property p_stat;
        $rose(LOCK_ELAPSED_O) |-> $past(LOCK_MODE_O) && $past(LOCK_MODE_O, 16);
    endproperty
    a_stat: assert property (p_stat) else $error("flag too early");
endmodule : ucs_synth_ctrl_checker
bind ucs_synth_ctrl ucs_synth_ctrl_checker i_chk (
    .CLK_I                 (CLK_I),
    .RESETN_I              (RESETN_I),
    .IO_WR_I               (IO_WR_I),
    .IO_RD_I               (IO_RD_I),
    .IO_SEL_O              (IO_SEL_O),
    .IO_ADDR_I             (IO_ADDR_I),
    .IO_WDATA_I            (IO_WDATA_I),
    .IO_RDATA_O            (IO_RDATA_O),
    .SYNTH_SOURCE_SELECT_I (SYNTH_SOURCE_SELECT_I),
    .SYNTH_USED_O          (SYNTH_USED_O),
    .OSC_ENABLE_O          (OSC_ENABLE_O),
    .LOCK_MODE_O           (LOCK_MODE_O),
    .LOCK_ELAPSED_O        (LOCK_ELAPSED_O),
    .SCALE_FACTOR_CODE_O   (SCALE_FACTOR_CODE_O),
    .SCALE_K_O             (SCALE_K_O),
    .RATIO_O               (RATIO_O)
);

/* File: test_usb_analog_pll_control.sv */
`timescale 1ns/1ps
module test_usb_analog_pll_control;
    logic        CLK_I = 1'b0;
    logic        RESETN_I = 1'b0;
    logic        REF_CLK_I = 1'b0;
    logic        IO_WR_I = 1'b0;
    logic        IO_RD_I = 1'b0;
    logic        SYNTH_SOURCE_SELECT_I = 1'b0;
    logic [15:0] IO_ADDR_I = 16'h0000;
    logic [15:0] IO_WDATA_I = 16'h0000;
    logic [15:0] IO_RDATA_O;
    logic        IO_SEL_O, SYNTH_USED_O, OSC_ENABLE_O, LOCK_MODE_O, LOCK_ELAPSED_O;
    logic [3:0]  SCALE_FACTOR_CODE_O;
    logic [4:0]  SCALE_K_O;
    logic [2:0]  RATIO_O;
    logic [2:0]  rc = 3'h0;
    logic        ref_run = 1'b0;
    int          n_fail = 0;
    int          checks = 0;
    // Each row is the written word, the expected ratio code and oscillator enable.
    logic [19:0] rows [8] = '{20'h00008, 20'hf000a, 20'hf800a, 20'h10023,
                              20'hf0021, 20'h28025, 20'h38027, 20'h00059};
    ucs_synth_ctrl i_dut (
        .CLK_I                 (CLK_I),
        .RESETN_I              (RESETN_I),
        .REF_CLK_I             (REF_CLK_I),
        .IO_ADDR_I             (IO_ADDR_I),
        .IO_WR_I               (IO_WR_I),
        .IO_RD_I               (IO_RD_I),
        .IO_WDATA_I            (IO_WDATA_I),
        .IO_RDATA_O            (IO_RDATA_O),
        .IO_SEL_O              (IO_SEL_O),
        .SYNTH_SOURCE_SELECT_I (SYNTH_SOURCE_SELECT_I),
        .SYNTH_USED_O          (SYNTH_USED_O),
        .OSC_ENABLE_O          (OSC_ENABLE_O),
        .LOCK_MODE_O           (LOCK_MODE_O),
        .SCALE_FACTOR_CODE_O   (SCALE_FACTOR_CODE_O),
        .SCALE_K_O             (SCALE_K_O),
        .RATIO_O               (RATIO_O),
        .LOCK_ELAPSED_O        (LOCK_ELAPSED_O)
    );
    initial forever #2 CLK_I = ~CLK_I;
    always @(posedge CLK_I) begin
        rc <= rc + 3'h1;
        if (ref_run) REF_CLK_I <= rc[2];
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge CLK_I);
        IO_ADDR_I <= a;
        IO_WDATA_I <= d;
        IO_WR_I <= 1'b1;
        @(posedge CLK_I);
        IO_WR_I <= 1'b0;
        @(posedge CLK_I);
        #1;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge CLK_I);
        IO_ADDR_I <= a;
        IO_RD_I <= 1'b1;
        #1;
        chk(IO_SEL_O, a == 16'h1f00);
        @(posedge CLK_I);
        IO_RD_I <= 1'b0;
        #1;
        chk(IO_RDATA_O, exp);
    endtask : rd
    task automatic tally_and_finish;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (5000) @(posedge CLK_I);
        n_fail++;
        tally_and_finish;
    end
    initial begin
        repeat (20) @(posedge CLK_I);
        RESETN_I <= 1'b1;
        rd(16'h1f00, 16'h0000);
        chk(RATIO_O, 3'h4);
        chk(SYNTH_USED_O, 1'b0);
        foreach (rows[i]) begin
            wr(16'h1f00, rows[i][19:4]);
            chk(RATIO_O, rows[i][3:1]);
            chk(OSC_ENABLE_O, rows[i][0]);
            chk(SCALE_K_O, rows[i][19:16] + 5'h01);
            chk(SCALE_FACTOR_CODE_O, rows[i][19:16]);
            rd(16'h1f00, rows[i][19:4] & 16'hfffe);
        end
        // A 12 MHz reference times a K of four gives the 48 MHz the USB core needs.
        wr(16'h1f00, 16'h3002);
        chk(RATIO_O, 3'h1);
        chk(SCALE_K_O, 5'h04);
        // The countdown is loaded while still in bypass, before lock mode is chosen.
        wr(16'h1f00, 16'h0010);
        ref_run <= 1'b1;
        wr(16'h1f00, 16'h0012);
        repeat (96) @(posedge CLK_I);
        #1;
        chk(LOCK_ELAPSED_O, 1'b0);
        repeat (95) @(posedge CLK_I);
        rd(16'h1f00, 16'h000a);
        repeat (100) @(posedge CLK_I);
        #1;
        chk(LOCK_ELAPSED_O, 1'b1);
        rd(16'h1f00, 16'h0003);
        wr(16'h1f00, 16'h0010);
        chk(LOCK_ELAPSED_O, 1'b0);
        repeat (300) @(posedge CLK_I);
        rd(16'h1f00, 16'h0010);
        wr(16'h1f01, 16'hf006);
        chk(LOCK_MODE_O, 1'b0);
        rd(16'h1f01, 16'h0000);
        SYNTH_SOURCE_SELECT_I <= 1'b1;
        repeat (2) @(posedge CLK_I);
        #1;
        chk(SYNTH_USED_O, 1'b1);
        wr(16'h1f00, 16'hf006);
        RESETN_I <= 1'b0;
        repeat (3) @(posedge CLK_I);
        RESETN_I <= 1'b1;
        rd(16'h1f00, 16'h0000);
        chk(RATIO_O, 3'h4);
        chk(OSC_ENABLE_O, 1'b0);
        chk(LOCK_MODE_O, 1'b0);
        tally_and_finish;
    end
endmodule : test_usb_analog_pll_control
